// File: inc/mlr_pkg.sv
/*
 * constants of the local control, status and interrupt register bank.
 * assumes one bus clock for the bus, the monitor macro and the bank.
 */
// Functional notes
// - status bit 11 shows an external port transaction in progress
// - status bit 10 sets on external write, clears on fabric access success
// - status bit 9 shows external lock; fabric accesses fail while locked
// - status bit 8 is high during each conversion
// - status bit 7 sets at sequence end, clears on status read
// - status bit 6 sets at conversion end, clears on status read
// - status bits 5:0 hold channel, updated at each conversion end
// - status and alarm status are read-only; writes change nothing
// - alarm bit 16 ORs alarms 8..14, bit 8 ORs alarms 0..6
// - alarm bits 12:9 user supplies, 4..0 ram, aux, core, temp, overtemp
// - trigger register bit ORed with external trigger input
// - trigger bits 17:2 hold temperature wait count, reset 0x03e8
// - trigger bit 1 enables periodic temperature reads to the output
// - macro reset bit holds macro in reset until cleared
// - macro reset clears alarm outputs, not interrupt registers
// - interrupt logic only when include parameter is 1; rising edges except bits 9 and 8
// - global enable bit 31 gates the interrupt output
// - interrupt status bits toggle on write of 1, clear on reset
// - interrupt bits 17:14 user alarms, bit 10 ram alarm
// - interrupt bits 9 and 8 catch falling temp and overtemp alarms
// - interrupt enable bits gate status onto the output
package mlr_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_ALARM = 12'h008;
    localparam logic [11:0] OFF_TRIGGER = 12'h00c;
    localparam logic [11:0] OFF_MACRO_RST = 12'h010;
    localparam logic [11:0] OFF_GIE = 12'h05c;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h060;
    localparam logic [11:0] OFF_IRQ_ENABLE = 12'h068;
    localparam logic [3:0] FULL_STROBE = 4'hf;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int TRIG_BIT = 0;
    localparam int TEMP_EN_BIT = 1;
    localparam int WAIT_LSB = 2;
    localparam int WAIT_MSB = 17;
    localparam logic [15:0] WAIT_RESET = 16'h03e8;
    localparam int GIE_BIT = 31;
    localparam int IRQ_W = 18;
    // positions holding an interrupt source; 13:11 are empty
    localparam logic [17:0] IRQ_PRESENT = 18'h3c7ff;
    // positions caught on a falling edge
    localparam logic [17:0] IRQ_FALLING = 18'h00300;
endpackage : mlr_pkg

// File: core/mlr_irq_bit.sv
/*
 * one interrupt status bit: edge capture with toggle-on-write.
 * assumes source and toggle are on sys_clk.
 */
`timescale 1ns/1ps
module mlr_irq_bit #(
    parameter bit FALLING = 1'b0
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic source,
    input wire logic toggle,
    output logic flag
);
    import mlr_pkg::*;

    logic prevSource;
    wire sawEvent = FALLING ? (prevSource & ~source) : (~prevSource & source);
    // event wins over a toggle in the same cycle
    wire next_flag = sawEvent ? 1'b1 : (toggle ? ~flag : flag);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prevSource <= 1'b0;
            flag <= 1'b0;
        end else begin
            prevSource <= source;
            flag <= next_flag;
        end
    end

    a_event_sets: assert property (@(posedge sys_clk) disable iff (reset)
        sawEvent |=> flag)
        else $error("edge event did not set status bit");
    a_toggle_flips: assert property (@(posedge sys_clk) disable iff (reset)
        (toggle && !sawEvent) |=> (flag != $past(flag)))
        else $error("write of one did not toggle status bit");
    a_idle_holds: assert property (@(posedge sys_clk) disable iff (reset)
        (!toggle && !sawEvent) |=> $stable(flag))
        else $error("status bit moved without cause");
endmodule : mlr_irq_bit

// File: core/mlr_local_regs.sv
/*
 * local register bank: axi4-lite slave, status, alarm status, trigger,
 * macro reset, temperature update and interrupt controller.
 * assumes the monitor macro and the bus share sys_clk; macro event
 * inputs are one-cycle pulses.
 */
`timescale 1ns/1ps
module mlr_local_regs #(
    parameter bit INCLUDE_IRQ_PARAM = 1'b1
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [mlr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [mlr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic adcBusy,
    input wire logic convDone,
    input wire logic sequenceDone,
    input wire logic [5:0] channel,
    input wire logic [14:0] alarmVector,
    input wire logic overtempAlarm,
    input wire logic externalAccessBusy,
    input wire logic externalWrite,
    input wire logic externalLockSignal,
    input wire logic fabricAccessReq,
    input wire logic fabricAccessDone,
    input wire logic extConvertTrigger,
    input wire logic [15:0] tempReadData,
    input wire logic tempReadValid,
    output logic convertTrigger,
    output logic macroReset,
    output logic fabricAccessGrant,
    output logic tempReadReq,
    output logic [15:0] tempOut,
    output logic irqOut
);
    import mlr_pkg::*;

    logic convDoneFlag;
    logic seqDoneFlag;
    logic externalWriteFlag;
    logic [5:0] channelReg;
    logic trigBit;
    logic tempUpdateEn;
    logic [15:0] waitCount;
    logic [15:0] tempCount;
    logic globalIrqEnable;
    logic [IRQ_W-1:0] irqEnable;
    logic [IRQ_W-1:0] irqStatus;
    logic [IRQ_W-1:0] irqSource;

    // bus handshake
    wire wrFire = s_axi_awready;
    wire rdFire = s_axi_arready;
    wire fullWord = (s_axi_wstrb == FULL_STROBE);
    wire wrTrigger = wrFire && fullWord && (s_axi_awaddr == OFF_TRIGGER);
    wire wrMacroRst = wrFire && fullWord && (s_axi_awaddr == OFF_MACRO_RST);
    wire wrGie = wrFire && fullWord && (s_axi_awaddr == OFF_GIE);
    wire wrIrqStatus = wrFire && fullWord
        && (s_axi_awaddr == OFF_IRQ_STATUS);
    wire wrIrqEnable = wrFire && fullWord
        && (s_axi_awaddr == OFF_IRQ_ENABLE);
    wire wrMapped = (s_axi_awaddr == OFF_STATUS)
        || (s_axi_awaddr == OFF_ALARM) || (s_axi_awaddr == OFF_TRIGGER)
        || (s_axi_awaddr == OFF_MACRO_RST) || (s_axi_awaddr == OFF_GIE)
        || (s_axi_awaddr == OFF_IRQ_STATUS)
        || (s_axi_awaddr == OFF_IRQ_ENABLE);
    wire rdStatus = rdFire && (s_axi_araddr == OFF_STATUS);
    wire next_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_awready
        && !s_axi_bvalid;
    wire next_arready = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

    // alarms from the macro read as cleared while it is held in reset
    wire [14:0] liveAlarm = macroReset ? 15'h0000 : alarmVector;
    wire liveOvertemp = overtempAlarm && !macroReset;

    wire [31:0] statusWord = {20'h00000, externalAccessBusy,
        externalWriteFlag, externalLockSignal, adcBusy,
        seqDoneFlag, convDoneFlag, channelReg};
    wire [31:0] alarmWord = {15'h0000, |liveAlarm[14:8], 3'h0,
        liveAlarm[11:8], |liveAlarm[6:0], 3'h0,
        liveAlarm[3:0], liveOvertemp};
    wire [31:0] gieWord = {globalIrqEnable, 31'h00000000};
    wire [31:0] irqStatusWord = {14'h0000, irqStatus};
    wire [31:0] irqEnableWord = {14'h0000, irqEnable};
    wire irqVisible = INCLUDE_IRQ_PARAM;
    wire rdMapped = (s_axi_araddr == OFF_STATUS)
        || (s_axi_araddr == OFF_ALARM) || (s_axi_araddr == OFF_TRIGGER)
        || (s_axi_araddr == OFF_MACRO_RST) || (s_axi_araddr == OFF_GIE)
        || (s_axi_araddr == OFF_IRQ_STATUS)
        || (s_axi_araddr == OFF_IRQ_ENABLE);
    // write-only registers read as zero
    wire [31:0] readWord =
        (s_axi_araddr == OFF_STATUS) ? statusWord :
        (s_axi_araddr == OFF_ALARM) ? alarmWord :
        (s_axi_araddr == OFF_GIE && irqVisible) ? gieWord :
        (s_axi_araddr == OFF_IRQ_STATUS && irqVisible) ? irqStatusWord :
        (s_axi_araddr == OFF_IRQ_ENABLE && irqVisible) ? irqEnableWord :
        32'h00000000;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
        end else begin
            s_axi_awready <= next_awready;
            s_axi_wready <= next_awready;
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (fullWord && wrMapped) ? RESP_OKAY
                    : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= next_arready;
            if (rdFire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= readWord;
                s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // status flags; a new event wins over the clear by read or access
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            convDoneFlag <= 1'b0;
            seqDoneFlag <= 1'b0;
            externalWriteFlag <= 1'b0;
            channelReg <= 6'h00;
            fabricAccessGrant <= 1'b0;
        end else begin
            convDoneFlag <= convDone || (convDoneFlag && !rdStatus);
            seqDoneFlag <= sequenceDone
                || (seqDoneFlag && !rdStatus);
            externalWriteFlag <= externalWrite
                || (externalWriteFlag && !fabricAccessDone);
            if (convDone) begin
                channelReg <= channel;
            end
            fabricAccessGrant <= fabricAccessReq && !externalLockSignal;
        end
    end

    // control registers written by software
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            trigBit <= 1'b0;
            tempUpdateEn <= 1'b0;
            waitCount <= WAIT_RESET;
            macroReset <= 1'b0;
            convertTrigger <= 1'b0;
        end else begin
            if (wrTrigger) begin
                trigBit <= s_axi_wdata[TRIG_BIT];
                tempUpdateEn <= s_axi_wdata[TEMP_EN_BIT];
                waitCount <= s_axi_wdata[WAIT_MSB:WAIT_LSB];
            end
            if (wrMacroRst) begin
                macroReset <= s_axi_wdata[0];
            end
            convertTrigger <= trigBit || extConvertTrigger;
        end
    end

    // periodic temperature read
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tempCount <= WAIT_RESET;
            tempReadReq <= 1'b0;
            tempOut <= 16'h0000;
        end else begin
            if (!tempUpdateEn) begin
                tempCount <= waitCount;
                tempReadReq <= 1'b0;
            end else if (tempCount == 16'h0000) begin
                tempCount <= waitCount;
                tempReadReq <= 1'b1;
            end else begin
                tempCount <= tempCount - 16'h0001;
                tempReadReq <= 1'b0;
            end
            if (tempReadValid && tempUpdateEn) begin
                tempOut <= tempReadData;
            end
        end
    end

    // interrupt sources by status position
    assign irqSource = {liveAlarm[11:8], 3'h0, liveAlarm[3],
        liveAlarm[0], liveOvertemp, externalWrite, externalLockSignal,
        convDone, sequenceDone, liveAlarm[2:0], liveOvertemp};

    generate
        if (INCLUDE_IRQ_PARAM) begin : g_irq
            for (genvar i = 0; i < IRQ_W; i++) begin : g_bit
                if (IRQ_PRESENT[i]) begin : g_used
                    mlr_irq_bit #(
                        .FALLING(IRQ_FALLING[i])
                    ) u_bit (
                        .sys_clk(sys_clk),
                        .reset(reset),
                        .source(irqSource[i]),
                        .toggle(wrIrqStatus && s_axi_wdata[i]),
                        .flag(irqStatus[i])
                    );
                end else begin : g_empty
                    assign irqStatus[i] = 1'b0;
                end
            end
        end else begin : g_no_irq
            assign irqStatus = '0;
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            globalIrqEnable <= 1'b0;
            irqEnable <= '0;
            irqOut <= 1'b0;
        end else begin
            if (wrGie) begin
                globalIrqEnable <= s_axi_wdata[GIE_BIT];
            end
            if (wrIrqEnable) begin
                irqEnable <= s_axi_wdata[IRQ_W-1:0] & IRQ_PRESENT;
            end
            irqOut <= irqVisible && globalIrqEnable
                && |(irqStatus & irqEnable);
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence s_write_taken;
        s_axi_awvalid && s_axi_wvalid && s_axi_awready;
    endsequence
    sequence s_write_answered;
        s_axi_bvalid ##0 (s_axi_bresp == ($past(fullWord && wrMapped)
            ? RESP_OKAY : RESP_SLVERR));
    endsequence

    a_write_resp: assert property (s_write_taken |=> s_write_answered)
        else $error("write not answered next cycle");
    a_status_clear: assert property (rdStatus && !convDone
        |=> !convDoneFlag)
        else $error("conversion flag survived status read");
    a_seq_set: assert property (sequenceDone |=> seqDoneFlag)
        else $error("sequence flag not set");
    a_ext_write: assert property (externalWrite |=> externalWriteFlag)
        else $error("external write flag not set");
    a_lock_blocks: assert property (fabricAccessGrant
        |-> !$past(externalLockSignal))
        else $error("fabric access granted while locked");
    a_trigger_or: assert property (##1 convertTrigger
        == $past(trigBit || extConvertTrigger))
        else $error("trigger output not the OR of its sources");
    a_channel_hold: assert property (!convDone |=> $stable(channelReg))
        else $error("channel changed without conversion end");
    a_alarm_reset: assert property (macroReset |-> alarmWord == 32'h0)
        else $error("alarms visible during macro reset");
    a_temp_off: assert property (!tempUpdateEn |=> !tempReadReq)
        else $error("temperature read while disabled");
    a_irq_gate: assert property (##1 irqOut == $past(irqVisible
        && globalIrqEnable && |(irqStatus & irqEnable)))
        else $error("interrupt output wrong");
    a_status_ro: assert property (wrFire && s_axi_awaddr == OFF_STATUS
        && !convDone && !sequenceDone && !rdStatus
        |=> $stable(convDoneFlag) && $stable(seqDoneFlag))
        else $error("write changed status register");
    a_seq_clear: assert property (rdStatus && !sequenceDone
        |=> !seqDoneFlag)
        else $error("sequence flag survived status read");
    a_gie_write: assert property (wrGie |=> globalIrqEnable
        == $past(s_axi_wdata[GIE_BIT]))
        else $error("global enable not written");
    a_enable_write: assert property (wrIrqEnable |=> irqEnable
        == ($past(s_axi_wdata[IRQ_W-1:0]) & IRQ_PRESENT))
        else $error("interrupt enable not written");
endmodule : mlr_local_regs

// File: verification/mlr_macro_model.sv
/*
 * monitor macro model: conversions, alarm levels, temperature reads.
 * assumes it shares sys_clk with the register bank.
 */
`timescale 1ns/1ps
module mlr_macro_model #(
    parameter logic [15:0] TEMP_VAL = 16'h0b6e
) (
    input wire logic sys_clk,
    input wire logic convertTrigger,
    input wire logic macroReset,
    input wire logic tempReadReq,
    input wire logic [14:0] alarmSet,
    input wire logic otSet,
    output logic adcBusy,
    output logic convDone,
    output logic sequenceDone,
    output logic [5:0] channel,
    output logic [14:0] alarmVector,
    output logic overtempAlarm,
    output logic [15:0] tempReadData,
    output logic tempReadValid
);
    logic trigQ;
    logic rstQ;
    int busyCnt;
    // alarms forced low while the macro is held in reset
    assign alarmVector = macroReset ? 15'h0000 : alarmSet;
    assign overtempAlarm = macroReset ? 1'b0 : otSet;
    initial begin
        trigQ = 1'b0;
        rstQ = 1'b0;
        busyCnt = 0;
        adcBusy = 1'b0;
        convDone = 1'b0;
        sequenceDone = 1'b0;
        channel = 6'h00;
        tempReadData = 16'h0000;
        tempReadValid = 1'b0;
    end
    always @(posedge sys_clk) begin
        trigQ <= convertTrigger;
        rstQ <= macroReset;
        convDone <= 1'b0;
        sequenceDone <= 1'b0;
        tempReadValid <= tempReadReq;
        // released data bus shows the inverse of the last value
        tempReadData <= tempReadReq ? TEMP_VAL : ~tempReadData;
        // rising trigger or reset release starts a conversion
        if ((convertTrigger && !trigQ) || (rstQ && !macroReset)) begin
            busyCnt <= 20;
            adcBusy <= 1'b1;
        end else if (busyCnt == 1) begin
            busyCnt <= 0;
            adcBusy <= 1'b0;
            convDone <= 1'b1;
            sequenceDone <= 1'b1;
            channel <= channel + 6'h01;
        end else if (busyCnt > 0) begin
            busyCnt <= busyCnt - 1;
        end
    end
endmodule : mlr_macro_model

// File: verification/mlr_local_regs_tb_top.sv
/*
 * self-checking bench of the local register bank.
 * assumes the macro model on the far side; inputs change at negedge.
 */
`timescale 1ns/1ps
module mlr_local_regs_tb_top;
    import mlr_pkg::*;
    localparam logic [15:0] TEMP_VAL = 16'h0b6e;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] s_axi_awaddr = '0;
    logic [ADDR_W-1:0] s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic externalAccessBusy = 1'b0, externalWrite = 1'b0;
    logic externalLockSignal = 1'b0, fabricAccessReq = 1'b0;
    logic fabricAccessDone = 1'b0, extConvertTrigger = 1'b0, otSet = 1'b0;
    logic [14:0] alarmSet = '0, alarmVector;
    logic adcBusy, convDone, sequenceDone, overtempAlarm, tempReadValid;
    logic convertTrigger, macroReset, fabricAccessGrant, tempReadReq, irqOut;
    logic [5:0] channel, expChan = 6'h00;
    logic [15:0] tempReadData, tempOut;
    int errors = 0, n_tests = 0;
    always #5 sys_clk = ~sys_clk;
    mlr_local_regs #(.INCLUDE_IRQ_PARAM(1'b1)) uut (.*,
        .s_axi_bready(1'b1), .s_axi_rready(1'b1));
    mlr_macro_model #(.TEMP_VAL(TEMP_VAL)) partner (.sys_clk(sys_clk),
        .convertTrigger(convertTrigger), .macroReset(macroReset),
        .tempReadReq(tempReadReq), .alarmSet(alarmSet), .otSet(otSet),
        .adcBusy(adcBusy), .convDone(convDone),
        .sequenceDone(sequenceDone), .channel(channel),
        .alarmVector(alarmVector), .overtempAlarm(overtempAlarm),
        .tempReadData(tempReadData), .tempReadValid(tempReadValid));
    task automatic results;
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    // one write; valids held through the edge that takes them
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s, input logic [1:0] expResp);
        int n;
        n = 0;
        s_axi_awaddr = a;
        s_axi_wdata = d;
        s_axi_wstrb = s;
        s_axi_awvalid = 1'b1;
        s_axi_wvalid = 1'b1;
        do begin tick(1); n++; end while (s_axi_awready !== 1'b1 && n < 20);
        do begin tick(1); n++; end while (s_axi_bvalid !== 1'b1 && n < 40);
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        chk({31'h0, s_axi_bvalid}, 32'h1);
        chk({30'h0, s_axi_bresp}, {30'h0, expResp});
        tick(1);
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
            output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr = a;
        s_axi_arvalid = 1'b1;
        do begin tick(1); n++; end while (s_axi_arready !== 1'b1 && n < 20);
        do begin tick(1); n++; end while (s_axi_rvalid !== 1'b1 && n < 40);
        s_axi_arvalid = 1'b0;
        chk({31'h0, s_axi_rvalid}, 32'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        tick(1);
    endtask : rd
    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, exp);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask : rdChk
    task automatic irqScenario;
        rdChk(OFF_GIE, 32'h0);
        rdChk(OFF_IRQ_STATUS, 32'h0);
        rdChk(OFF_IRQ_ENABLE, 32'h0);
        wr(OFF_IRQ_ENABLE, 32'h100, FULL_STROBE, RESP_OKAY);
        otSet = 1'b1;
        tick(3);
        otSet = 1'b0;
        tick(4);
        chk({31'h0, irqOut}, 32'h0);
        wr(OFF_GIE, 32'h8000_0000, FULL_STROBE, RESP_OKAY);
        tick(3);
        chk({31'h0, irqOut}, 32'h1);
        rdChk(OFF_IRQ_STATUS, 32'h101);
        wr(OFF_IRQ_STATUS, 32'h100, FULL_STROBE, RESP_OKAY);
        rdChk(OFF_IRQ_STATUS, 32'h1);
        tick(3);
        chk({31'h0, irqOut}, 32'h0);
        wr(OFF_IRQ_STATUS, 32'h1, FULL_STROBE, RESP_OKAY);
        rdChk(OFF_IRQ_STATUS, 32'h0);
    endtask : irqScenario
    task automatic statusScenario;
        externalAccessBusy = 1'b1;
        externalLockSignal = 1'b1;
        externalWrite = 1'b1;
        tick(1);
        externalWrite = 1'b0;
        fabricAccessReq = 1'b1;
        tick(1);
        fabricAccessReq = 1'b0;
        chk({31'h0, fabricAccessGrant}, 32'h0);
        rdChk(OFF_STATUS, 32'he00);
        externalLockSignal = 1'b0;
        fabricAccessReq = 1'b1;
        tick(1);
        fabricAccessReq = 1'b0;
        chk({31'h0, fabricAccessGrant}, 32'h1);
        fabricAccessDone = 1'b1;
        tick(1);
        fabricAccessDone = 1'b0;
        rdChk(OFF_STATUS, 32'h800);
        externalAccessBusy = 1'b0;
    endtask : statusScenario
    task automatic convScenario(input logic useExt);
        if (useExt) begin
            extConvertTrigger = 1'b1;
            tick(1);
            extConvertTrigger = 1'b0;
        end else begin
            wr(OFF_TRIGGER, 32'h1, FULL_STROBE, RESP_OKAY);
            wr(OFF_TRIGGER, 32'h0, FULL_STROBE, RESP_OKAY);
        end
        rdChk(OFF_STATUS, {23'h0, 3'b100, expChan});
        tick(25);
        expChan++;
        rdChk(OFF_STATUS, {24'h0, 2'b11, expChan});
        rdChk(OFF_STATUS, {26'h0, expChan});
    endtask : convScenario
    task automatic alarmScenario;
        logic [31:0] exp, s0;
        logic [1:0] r;
        alarmSet = 15'h0506;
        exp = 32'h0001_0b0c;
        tick(3);
        rdChk(OFF_ALARM, exp);
        wr(OFF_ALARM, 32'hffff_ffff, FULL_STROBE, RESP_OKAY);
        rdChk(OFF_ALARM, exp);
        wr(OFF_STATUS, 32'hffff_ffff, FULL_STROBE, RESP_OKAY);
        rdChk(OFF_STATUS, {26'h0, expChan});
        rd(OFF_IRQ_STATUS, s0, r);
        wr(OFF_MACRO_RST, 32'h1, FULL_STROBE, RESP_OKAY);
        chk({31'h0, macroReset}, 32'h1);
        rdChk(OFF_ALARM, 32'h0);
        rdChk(OFF_IRQ_STATUS, s0);
        wr(OFF_MACRO_RST, 32'h0, FULL_STROBE, RESP_OKAY);
        chk({31'h0, macroReset}, 32'h0);
        tick(25);
        expChan++;
        rdChk(OFF_STATUS, {24'h0, 2'b11, expChan});
    endtask : alarmScenario
    task automatic tempScenario;
        int n;
        wr(OFF_TRIGGER, 32'h16, FULL_STROBE, RESP_OKAY);
        n = 0;
        while (tempReadReq !== 1'b1 && n < 40) begin tick(1); n++; end
        tick(1);
        n = 1;
        while (tempReadReq !== 1'b1 && n < 40) begin tick(1); n++; end
        chk(32'(n), 32'd6);
        tick(3);
        chk({16'h0, tempOut}, {16'h0, TEMP_VAL});
        wr(OFF_TRIGGER, 32'h14, FULL_STROBE, RESP_OKAY);
        n = 0;
        repeat (40) begin
            tick(1);
            if (tempReadReq === 1'b1) n++;
        end
        chk(32'(n), 32'd0);
    endtask : tempScenario
    task automatic errorScenario;
        logic [31:0] d;
        logic [1:0] r;
        rd(12'h100, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(OFF_GIE, 32'h0, 4'h3, RESP_SLVERR);
        rdChk(OFF_GIE, 32'h8000_0000);
    endtask : errorScenario
    task automatic resetScenario;
        alarmSet = 15'h0000;
        tick(2);
        reset = 1'b1;
        tick(2);
        reset = 1'b0;
        rdChk(OFF_GIE, 32'h0);
        rdChk(OFF_IRQ_STATUS, 32'h0);
        rdChk(OFF_IRQ_ENABLE, 32'h0);
        chk({31'h0, irqOut}, 32'h0);
    endtask : resetScenario
    initial begin
        tick(5);
        reset = 1'b0;
        irqScenario();
        statusScenario();
        convScenario(1'b0);
        convScenario(1'b1);
        alarmScenario();
        tempScenario();
        errorScenario();
        resetScenario();
        results();
    end
    initial begin
        #100us;
        errors++;
        $display("ERROR %0t: watchdog expired", $time);
        results();
    end
endmodule : mlr_local_regs_tb_top
